// ==== init_reset_pkg.sv ====
/*
  Constants shared by the initial reset generator and its helpers:
  clock rates, divider and filter counts, build-option codes and
  core supply level encodings.
  Assumes a 10 MHz core clock and a 32.768 kHz slow oscillator.
*/
`default_nettype none
package init_reset_pkg;

  // clock rates
  localparam int unsigned CORE_CLK_HZ      = 10_000_000;
  localparam int unsigned SLOW_OSC_HZ      = 32_768;

  // release strobe: 16 Hz divided from the slow oscillator
  localparam int unsigned RELEASE_HZ       = 16;
  localparam int unsigned DIV_TICKS        = SLOW_OSC_HZ / RELEASE_HZ;
  localparam int unsigned DIV_W            = $clog2(DIV_TICKS);

  // key-combination noise rejector, least time in microseconds
  localparam int unsigned NOISE_REJECT_US  = 1_500;
  localparam int unsigned NOISE_TICKS      = (NOISE_REJECT_US * SLOW_OSC_HZ) / 1_000_000;

  // time qualification window, 1 to 2 seconds; the lower bound is used
  localparam int unsigned QUAL_MIN_MS      = 1_000;
  localparam int unsigned QUAL_TICKS_DFLT  = (QUAL_MIN_MS * SLOW_OSC_HZ) / 1_000;

  // slow-tick counter width in the key qualifier
  localparam int unsigned CNT_W            = 16;

  // key-combination build option codes
  localparam logic [2:0] KEY_OPT_NONE      = 3'h1;
  localparam logic [2:0] KEY_OPT_K0123     = 3'h2;
  localparam logic [2:0] KEY_OPT_K012      = 3'h3;
  localparam logic [2:0] KEY_OPT_K01       = 3'h4;

  // supply detector threshold options, millivolts
  localparam int unsigned DET_MV_OPT1      = 1_800;
  localparam int unsigned DET_MV_OPT2      = 1_600;
  localparam int unsigned DET_MV_OPT3      = 1_400;

  // core logic supply levels
  localparam logic [1:0] VD_1V1            = 2'h0;
  localparam logic [1:0] VD_1V3            = 2'h1;
  localparam logic [1:0] VD_1V5            = 2'h2;
  localparam logic [1:0] VD_1V7            = 2'h3;

  // fast oscillator speed classes (700 kHz, 2.2 MHz, 4.2 MHz)
  localparam logic [1:0] FAST_700K         = 2'h0;
  localparam logic [1:0] FAST_2M2          = 2'h1;
  localparam logic [1:0] FAST_4M2          = 2'h2;

  // reset values
  localparam logic       INIT_RESET_RST    = 1'b1;
  localparam logic [1:0] VD_LEVEL_RST      = 2'h0;

endpackage
`default_nettype wire

// ==== level_sync.sv ====
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes nothing of the inputs; output is two core clocks late.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RV = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= RV;
      sync_out <= RV;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== key_qualifier.sv ====
/*
  Key-combination qualifier: noise rejector followed by an optional
  time-qualification stage, both counted in slow oscillator ticks.
  Assumes combo_low is already synchronous and slow_tick is a
  one-core-cycle pulse per slow oscillator rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module key_qualifier #(
  parameter bit                                  TIME_QUAL_EN = 1'b0,
  parameter logic [init_reset_pkg::CNT_W-1:0]    QUAL_TICKS   =
    init_reset_pkg::CNT_W'(init_reset_pkg::QUAL_TICKS_DFLT)
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // qualifier inputs
  input  wire logic combo_low,
  input  wire logic slow_tick,
  // request
  output var  logic key_req_r
);

  typedef enum logic [1:0] {
    KQ_IDLE   = 2'h0,
    KQ_FILTER = 2'h1,
    KQ_QUAL   = 2'h3,
    KQ_FIRE   = 2'h2
  } kq_state_t;

  localparam logic [init_reset_pkg::CNT_W-1:0] NOISE_LAST =
    init_reset_pkg::CNT_W'(init_reset_pkg::NOISE_TICKS - 1);

  kq_state_t                        state_r;
  kq_state_t                        state_nxt;
  logic [init_reset_pkg::CNT_W-1:0] cnt_r;
  logic [init_reset_pkg::CNT_W-1:0] cnt_nxt;
  logic                             key_req_nxt;

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    key_req_nxt = 1'b0;
    case (state_r)
      KQ_IDLE: begin
        cnt_nxt = '0;
        if (combo_low) begin
          state_nxt = KQ_FILTER;
        end
      end
      // no slow ticks before the oscillator runs, so nothing passes
      KQ_FILTER: begin
        if (!combo_low) begin
          state_nxt = KQ_IDLE;
        end else if (slow_tick) begin
          if (cnt_r == NOISE_LAST) begin
            cnt_nxt   = '0;
            state_nxt = TIME_QUAL_EN ? KQ_QUAL : KQ_FIRE;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      KQ_QUAL: begin
        if (!combo_low) begin
          state_nxt = KQ_IDLE;
        end else if (slow_tick) begin
          if (cnt_r == QUAL_TICKS - 1'b1) begin
            state_nxt = KQ_FIRE;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      KQ_FIRE: begin
        key_req_nxt = combo_low;
        if (!combo_low) begin
          state_nxt = KQ_IDLE;
        end
      end
      default: begin
        state_nxt = KQ_IDLE;
      end
    endcase
    if (state_nxt == KQ_FIRE && combo_low) begin
      key_req_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= KQ_IDLE;
      cnt_r     <= '0;
      key_req_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      key_req_r <= key_req_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== initial_reset_generator.sv ====
/*
  Initial reset generator: gathers the reset pin, the key combination
  and the supply detector into a set-reset latch released by a 16 Hz
  strobe divided from the slow oscillator. Also holds the core supply
  level and the shared-pin defaults while reset stands.
  Assumes every input is a level sampled on core_clk; slow_osc_clock is
  sampled as data, it is far slower than core_clk.
*/
//
// Summary of operation
// - reset from pin, keys, or supply detector
// - low reset pin sets the reset latch
// - latch clears only while 16 Hz strobe high
// - key request filtered for 1.5 ms
// - key filter idle until oscillator starts
// - four build choices of key group
// - all selected keys low raises request
// - optional 1 s qualification before key reset
// - supply detector with selectable threshold option
// - four core supply levels, set before clock
// - detector holds request while supply low
// - shared pins output high / pulled-up input
`timescale 1ns/1ps
`default_nettype none
module initial_reset_generator #(
  parameter logic [2:0]                       KEY_COMBO_OPT  = init_reset_pkg::KEY_OPT_K0123,
  parameter bit                               TIME_QUAL_EN   = 1'b0,
  parameter bit                               SUPPLY_DET_EN  = 1'b1,
  parameter int unsigned                      SUPPLY_DET_MV  = init_reset_pkg::DET_MV_OPT1,
  parameter logic [init_reset_pkg::CNT_W-1:0] QUAL_TICKS     =
    init_reset_pkg::CNT_W'(init_reset_pkg::QUAL_TICKS_DFLT)
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // reset sources
  input  wire logic       reset_pin_n,
  input  wire logic       key_input_0,
  input  wire logic       key_input_1,
  input  wire logic       key_input_2,
  input  wire logic       key_input_3,
  input  wire logic       supply_below_level,
  // slow oscillator, sampled as data
  input  wire logic       slow_osc_clock,
  // core supply and fast oscillator control from software
  input  wire logic [1:0] supply_level_sel,
  input  wire logic       fast_osc_req,
  input  wire logic [1:0] fast_osc_speed,
  // reset and status outputs
  output var  logic       init_reset,
  output var  logic       key_reset_active,
  output var  logic       slow_osc_running,
  // core supply and fast oscillator outputs
  output var  logic [1:0] core_supply_level,
  output var  logic       fast_osc_enable,
  // shared pin defaults
  output var  logic       out_port_force_high,
  output var  logic       io_port_force_pullup_in
);

  // least supply level that carries a given fast oscillator speed
  function automatic logic [1:0] level_for_speed(input logic [1:0] speed);
    case (speed)
      init_reset_pkg::FAST_700K: level_for_speed = init_reset_pkg::VD_1V3;
      init_reset_pkg::FAST_2M2:  level_for_speed = init_reset_pkg::VD_1V5;
      default:                   level_for_speed = init_reset_pkg::VD_1V7;
    endcase
  endfunction

  // selected key group mask for a build option
  function automatic logic [3:0] key_mask(input logic [2:0] opt);
    case (opt)
      init_reset_pkg::KEY_OPT_K0123: key_mask = 4'hF;
      init_reset_pkg::KEY_OPT_K012:  key_mask = 4'h7;
      init_reset_pkg::KEY_OPT_K01:   key_mask = 4'h3;
      default:                       key_mask = 4'h0;
    endcase
  endfunction

  localparam logic [3:0] KEY_MASK = key_mask(KEY_COMBO_OPT);

  // threshold is analogue; the option only has to be a legal one
  localparam bit DET_MV_LEGAL = (SUPPLY_DET_MV == init_reset_pkg::DET_MV_OPT1) ||
                                (SUPPLY_DET_MV == init_reset_pkg::DET_MV_OPT2) ||
                                (SUPPLY_DET_MV == init_reset_pkg::DET_MV_OPT3);
  localparam bit DET_ACTIVE   = SUPPLY_DET_EN && DET_MV_LEGAL;

  // synchronised inputs: reset pin, four keys, slow clock
  logic [5:0] raw_in;
  logic [5:0] sync_in;
  logic       pin_low;
  logic [3:0] keys_s;
  logic       slow_s;

  assign raw_in  = {slow_osc_clock, key_input_3, key_input_2, key_input_1, key_input_0, reset_pin_n};
  assign pin_low = !sync_in[0];
  assign keys_s  = sync_in[4:1];
  assign slow_s  = sync_in[5];

  level_sync #(
    .W  (6),
    .RV (6'h1F)
  ) u_in_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  // slow clock edge detect and 16 Hz divider
  logic                            slow_d_r;
  logic                            slow_d_nxt;
  logic                            slow_tick;
  logic [init_reset_pkg::DIV_W-1:0] div_r;
  logic [init_reset_pkg::DIV_W-1:0] div_nxt;
  logic                            strobe16_high;
  logic                            running_nxt;

  assign slow_tick     = slow_s && !slow_d_r;
  assign strobe16_high = div_r[init_reset_pkg::DIV_W-1];

  always_comb begin
    slow_d_nxt  = slow_s;
    div_nxt     = div_r;
    running_nxt = slow_osc_running;
    if (slow_tick) begin
      div_nxt     = div_r + 1'b1;
      running_nxt = 1'b1;
    end
  end

  // key combination: every selected key low, others ignored
  logic combo_low;
  logic key_req;

  assign combo_low = (KEY_MASK != 4'h0) && ((~keys_s & KEY_MASK) == KEY_MASK);

  key_qualifier #(
    .TIME_QUAL_EN (TIME_QUAL_EN),
    .QUAL_TICKS   (QUAL_TICKS)
  ) u_key_qual (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .combo_low (combo_low),
    .slow_tick (slow_tick),
    .key_req_r (key_req)
  );

  // supply detector request, held for as long as the supply is low
  logic det_req;

  assign det_req = DET_ACTIVE && supply_below_level;

  // reset latch: set wins, clear only while the strobe is high
  logic any_req;
  logic init_reset_nxt;
  logic key_active_nxt;

  assign any_req = pin_low || key_req || det_req;

  always_comb begin
    init_reset_nxt = init_reset;
    key_active_nxt = key_reset_active;
    if (any_req) begin
      init_reset_nxt = 1'b1;
      key_active_nxt = key_req || key_reset_active;
    end else if (strobe16_high) begin
      init_reset_nxt = 1'b0;
      key_active_nxt = 1'b0;
    end
  end

  // core supply level and fast oscillator gating
  logic [1:0] level_nxt;
  logic       fast_en_nxt;

  always_comb begin
    level_nxt   = supply_level_sel;
    fast_en_nxt = 1'b0;
    if (init_reset_nxt) begin
      level_nxt = init_reset_pkg::VD_LEVEL_RST;
    end else if (fast_osc_req && core_supply_level >= level_for_speed(fast_osc_speed)) begin
      // level must already stand before the fast clock runs
      fast_en_nxt = 1'b1;
    end
    if (!fast_osc_req && level_nxt != init_reset_pkg::VD_1V1 && !fast_osc_enable) begin
      // without the fast clock the level still follows supply_level_sel
      level_nxt = supply_level_sel;
    end
  end

  // shared pin defaults follow the latch
  logic out_high_nxt;
  logic io_pull_nxt;

  always_comb begin
    out_high_nxt = init_reset_nxt;
    io_pull_nxt  = init_reset_nxt;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slow_d_r         <= 1'b1;
      div_r            <= '0;
      slow_osc_running <= 1'b0;
    end else begin
      slow_d_r         <= slow_d_nxt;
      div_r            <= div_nxt;
      slow_osc_running <= running_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      init_reset       <= init_reset_pkg::INIT_RESET_RST;
      key_reset_active <= 1'b0;
    end else begin
      init_reset       <= init_reset_nxt;
      key_reset_active <= key_active_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_supply_level <= init_reset_pkg::VD_LEVEL_RST;
      fast_osc_enable   <= 1'b0;
    end else begin
      core_supply_level <= level_nxt;
      fast_osc_enable   <= fast_en_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_port_force_high     <= 1'b1;
      io_port_force_pullup_in <= 1'b1;
    end else begin
      out_port_force_high     <= out_high_nxt;
      io_port_force_pullup_in <= io_pull_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== initial_reset_generator_sva.sv ====
/*
  Port checker for the initial reset generator.
  Assumes the default build: supply detector on, four-key group.
*/
`timescale 1ns/1ps
`default_nettype none
module initial_reset_generator_sva (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // inputs
  input wire logic       reset_pin_n,
  input wire logic       supply_below_level,
  input wire logic       fast_osc_req,
  input wire logic [1:0] fast_osc_speed,
  // outputs
  input wire logic       init_reset,
  input wire logic       key_reset_active,
  input wire logic       slow_osc_running,
  input wire logic [1:0] core_supply_level,
  input wire logic       fast_osc_enable,
  input wire logic       out_port_force_high,
  input wire logic       io_port_force_pullup_in
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_pin_sets_latch: assert property (!reset_pin_n [*3] |=> init_reset)
    else $error("pin low did not set reset");
  a_pins_follow_reset: assert property (out_port_force_high == init_reset && io_port_force_pullup_in == init_reset)
    else $error("pin defaults differ from reset");
  // two sync flops on the pin, none on the detector
  a_release_no_request: assert property ($fell(init_reset) |-> $past(reset_pin_n, 3) && !$past(supply_below_level))
    else $error("reset released under a request");
  a_detector_sets: assert property (supply_below_level |=> init_reset)
    else $error("detector did not set reset");
  a_key_flag_in_reset: assert property (key_reset_active |-> init_reset)
    else $error("key flag outside reset");
  a_key_needs_osc: assert property ($rose(key_reset_active) |-> slow_osc_running)
    else $error("key reset before oscillator start");
  a_osc_flag_sticky: assert property (slow_osc_running |=> slow_osc_running)
    else $error("oscillator flag dropped");
  a_level_low_in_reset: assert property (init_reset |-> core_supply_level == 2'h0)
    else $error("supply level raised in reset");
  // speed class 3 falls back to the top level, like class 2
  a_fast_needs_level: assert property (fast_osc_enable |-> $past(fast_osc_req) &&
    ($past(core_supply_level) > $past(fast_osc_speed) || $past(core_supply_level) == 2'h3))
    else $error("fast oscillator on at low level");
endmodule

bind initial_reset_generator initial_reset_generator_sva sva_chk (
  .core_clk(core_clk), .resetn(resetn), .reset_pin_n(reset_pin_n), .supply_below_level(supply_below_level),
  .fast_osc_req(fast_osc_req), .fast_osc_speed(fast_osc_speed), .init_reset(init_reset),
  .key_reset_active(key_reset_active), .slow_osc_running(slow_osc_running),
  .core_supply_level(core_supply_level), .fast_osc_enable(fast_osc_enable),
  .out_port_force_high(out_port_force_high), .io_port_force_pullup_in(io_port_force_pullup_in));
`default_nettype wire

// ==== reset_key_partner.sv ====
/*
  Far side: external reset driver, key switches and slow oscillator.
  Assumes a free-running core clock; pins change 1 ns after its edge.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_key_partner #(
  parameter int HALF_CYC  = 4,
  parameter int START_CYC = 30,
  parameter int PWR_CYC   = 40,
  parameter int PIN_MIN   = 4
) (
  // clock
  input  wire logic       core_clk,
  // pins
  output var  logic       reset_pin_n,
  output var  logic [3:0] keys_n,
  output var  logic       slow_osc_clock
);
  int cyc = 0;

  initial begin
    reset_pin_n = 1'b0;
    keys_n = 4'hF;
    slow_osc_clock = 1'b0;
    repeat (PWR_CYC) @(posedge core_clk);
    #1 reset_pin_n = 1'b1;
  end

  // oscillator stands still until it starts, then free-runs
  always @(posedge core_clk) begin
    #1;
    cyc = cyc + 1;
    if (cyc >= START_CYC && (cyc - START_CYC) % HALF_CYC == 0) begin
      slow_osc_clock = ~slow_osc_clock;
    end
  end

  // short requests stretched to the least low time
  task automatic pin_pulse(input int n);
    reset_pin_n = 1'b0;
    repeat ((n > PIN_MIN) ? n : PIN_MIN) @(posedge core_clk);
    #1 reset_pin_n = 1'b1;
  endtask

  // released keys return high through their pull-ups
  task automatic set_keys(input logic [3:0] low_mask);
    keys_n = ~low_mask;
  endtask
endmodule
`default_nettype wire

// ==== initial_reset_generator_tb.sv ====
/*
  Self-checking bench for the initial reset generator.
  Assumes the partner drives pin, keys and a fast-scaled slow clock.
*/
`timescale 1ns/1ps
`default_nettype none
module initial_reset_generator_tb;
  // slow tick scaled to 8 core cycles to keep the run short
  localparam int TK = 8;
  logic       core_clk;
  logic       resetn;
  logic       reset_pin_n;
  logic [3:0] keys_n;
  logic       slow_osc_clock;
  logic       supply_below_level;
  logic [1:0] supply_level_sel;
  logic       fast_osc_req;
  logic [1:0] fast_osc_speed;
  logic       init_reset;
  logic       key_reset_active;
  logic       slow_osc_running;
  logic [1:0] core_supply_level;
  logic       fast_osc_enable;
  logic       out_port_force_high;
  logic       io_port_force_pullup_in;
  int         err_total = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n;

  reset_key_partner #(.HALF_CYC(TK / 2)) pm (.core_clk(core_clk), .reset_pin_n(reset_pin_n),
    .keys_n(keys_n), .slow_osc_clock(slow_osc_clock));

  initial_reset_generator #(.TIME_QUAL_EN(1'b1), .QUAL_TICKS(16'h0008)) dut (
    .core_clk(core_clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
    .key_input_0(keys_n[0]), .key_input_1(keys_n[1]), .key_input_2(keys_n[2]), .key_input_3(keys_n[3]),
    .supply_below_level(supply_below_level), .slow_osc_clock(slow_osc_clock),
    .supply_level_sel(supply_level_sel), .fast_osc_req(fast_osc_req), .fast_osc_speed(fast_osc_speed),
    .init_reset(init_reset), .key_reset_active(key_reset_active), .slow_osc_running(slow_osc_running),
    .core_supply_level(core_supply_level), .fast_osc_enable(fast_osc_enable),
    .out_port_force_high(out_port_force_high), .io_port_force_pullup_in(io_port_force_pullup_in));

  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_lvl(input logic v, input int max, output int c);
    c = 0;
    while (init_reset !== v && c < max) begin
      step(1);
      c++;
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic t_power_up;
    wait_lvl(1'b0, 9000, n);
    chk(n >= 1024 * TK - 20 && n <= 1024 * TK + 60, "power-up release time");
    chk(out_port_force_high === 1'b0 && io_port_force_pullup_in === 1'b0, "pins still forced");
  endtask

  task automatic t_pin;
    pm.pin_pulse(6);
    chk(init_reset === 1'b1 && out_port_force_high === 1'b1 && io_port_force_pullup_in === 1'b1, "pin reset");
    wait_lvl(1'b0, 1100 * TK, n);
    chk(init_reset === 1'b0 && n <= 1024 * TK + 40, "pin release late");
  endtask

  task automatic t_keys;
    pm.set_keys(4'h7);
    step(70 * TK);
    chk(init_reset === 1'b0, "partial key group reset");
    pm.set_keys(4'hF);
    step(30 * TK);
    chk(init_reset === 1'b0, "short key combination passed");
    pm.set_keys(4'h0);
    step(4);
    pm.set_keys(4'hF);
    wait_lvl(1'b1, 80 * TK, n);
    chk(n >= 55 * TK && n <= 58 * TK + 8, "key reset timing");
    chk(key_reset_active === 1'b1 && slow_osc_running === 1'b1, "key source flag");
    pm.set_keys(4'h0);
    wait_lvl(1'b0, 1100 * TK, n);
    chk(init_reset === 1'b0 && key_reset_active === 1'b0, "key release");
  endtask

  task automatic t_supply;
    supply_level_sel = 2'h3;
    supply_below_level = 1'b1;
    step(3);
    chk(init_reset === 1'b1 && core_supply_level === 2'h0, "supply reset");
    supply_below_level = 1'b0;
    wait_lvl(1'b0, 1100 * TK, n);
    chk(init_reset === 1'b0, "supply release");
  endtask

  task automatic t_levels;
    fast_osc_req = 1'b1;
    for (int s = 0; s < 3; s++) begin
      fast_osc_speed = 2'(s);
      supply_level_sel = 2'(s);
      step(3);
      chk(fast_osc_enable === 1'b0, "fast osc on at low level");
      supply_level_sel = 2'(s + 1);
      step(3);
      chk(fast_osc_enable === 1'b1, "fast osc refused");
    end
    fast_osc_speed = 2'h3;
    step(3);
    chk(fast_osc_enable === 1'b1, "fast osc refused at top class");
    fast_osc_req = 1'b0;
    step(3);
    chk(fast_osc_enable === 1'b0 && core_supply_level === 2'h3, "fast osc without request");
  endtask

  // divider restarts from zero, so the full 1024-tick wait returns
  task automatic t_reset_again;
    resetn = 1'b0;
    step(2);
    chk(init_reset === 1'b1 && key_reset_active === 1'b0 && slow_osc_running === 1'b0, "mid-run reset state");
    chk(core_supply_level === 2'h0 && fast_osc_enable === 1'b0 && out_port_force_high === 1'b1, "mid-run outputs");
    resetn = 1'b1;
    step(2);
    chk(init_reset === 1'b1 && slow_osc_running === 1'b0, "early release after reset");
    wait_lvl(1'b0, 9000, n);
    chk(n >= 1024 * TK - 20 && n <= 1024 * TK + 60 && slow_osc_running === 1'b1, "second release time");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      $display("[FAIL] %0t run too long", $time);
      summarize();
    end
  end

  initial begin
    resetn = 1'b0;
    supply_below_level = 1'b0;
    supply_level_sel = 2'h0;
    fast_osc_req = 1'b0;
    fast_osc_speed = 2'h0;
    step(20);
    chk(init_reset === 1'b1 && out_port_force_high === 1'b1 && io_port_force_pullup_in === 1'b1, "reset state");
    resetn = 1'b1;
    t_power_up();
    t_pin();
    t_keys();
    t_supply();
    t_levels();
    t_reset_again();
    summarize();
  end
endmodule
`default_nettype wire
